// file: rtl/dmt_pkg.sv
package dmt_pkg;

  // =====================================================================
  // register offsets (byte addresses on the 3-bit register port)
  // =====================================================================
  localparam logic [2:0] OFS_CTRL     = 3'h0;
  localparam logic [2:0] OFS_STAT     = 3'h1;
  localparam logic [2:0] OFS_CNT_HI   = 3'h2;
  localparam logic [2:0] OFS_CNT_LO   = 3'h3;
  localparam logic [2:0] OFS_CMP_HI   = 3'h4;
  localparam logic [2:0] OFS_CMP_LO   = 3'h5;
  localparam logic [2:0] OFS_CFG      = 3'h6;

  // =====================================================================
  // timer_control_reg fields
  // =====================================================================
  localparam int CTL_UPPER_LEVEL = 7;
  localparam int CTL_UPPER_CS_HI = 6;
  localparam int CTL_UPPER_CS_LO = 4;
  localparam int CTL_LOWER_LEVEL = 3;
  localparam int CTL_LOWER_CS_HI = 2;
  localparam int CTL_LOWER_CS_LO = 0;

  // =====================================================================
  // timer_ctl_status_reg fields
  // =====================================================================
  localparam int ST_UPPER_OVF  = 7;
  localparam int ST_UPPER_CMF  = 6;
  localparam int ST_UPPER_OVIE = 5;
  localparam int ST_UPPER_CCLR = 4;
  localparam int ST_LOWER_OVF  = 3;
  localparam int ST_LOWER_CMF  = 2;
  localparam int ST_LOWER_OVIE = 1;
  localparam int ST_LOWER_CCLR = 0;
  localparam logic [7:0] ST_FLAG_MASK = 8'hCC;

  // =====================================================================
  // edge and interrupt enable fields
  // =====================================================================
  localparam int CFG_EDGE_RISE = 0;
  localparam int CFG_UPPER_IEN = 1;
  localparam int CFG_LOWER_IEN = 2;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'hFFFF;
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [7:0]  RST_STAT    = 8'h00;
  localparam logic [2:0]  RST_CFG     = 3'h0;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dmt_bus_type;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  stat;
    logic [2:0]  cfg;
    logic [15:0] cnt;
    logic [15:0] cmp;
    logic [7:0]  temp;
    logic [7:0]  armed;
    logic [4:0]  pre;
    logic        evt_prev;
    logic        pin_hi;
    logic        pin_lo;
    logic        irq_hi;
    logic        irq_lo;
    logic [7:0]  rdata;
  } dmt_state_type;

endpackage : dmt_pkg

// file: rtl/dmt_timer.sv
// Functional notes
// - clksel high bit picks 16-bit or 8-bit
// - reset: count 0000, compare FFFF, controls 00
// - four prescaled clocks: /32 /16 /4 /2
// - lower external event, edge selectable
// - 16-bit compare sets upper compare flag
// - match fires on the tick leaving match
// - upper match: interrupt if enabled, toggle pin
// - upper clear bit clears counter on match
// - 16-bit wrap sets upper overflow, gated interrupt
// - 8-bit halves compare, flag, toggle, clear
// - 8-bit half wrap sets its overflow flag
// - pins follow level bit, invert on match
// - control write beats toggle on pin
// - compare write suppresses coincident match
// - 8-bit matches only on that half's clock tick, 16-bit match on the lower tick
// - lower flags still work in 16-bit mode
// - count write drops coincident overflow
// - counter halts in low power, registers kept
// - flags cleared by zero after read one
module dmt_timer (
  input  wire logic                 clk_in,
  input  wire logic                 rst_b_in,
  input  wire dmt_pkg::dmt_bus_type bus_in,
  input  wire logic                 event_count_input_in,
  input  wire logic                 power_halt_in,
  output logic [7:0]                rdata_out,
  output logic                      upper_compare_out,
  output logic                      lower_compare_out,
  output logic                      upper_irq_out,
  output logic                      lower_irq_out
);

  // =====================================================================
  // helpers
  // =====================================================================
  function automatic logic dmt_tick(input logic [1:0] sel,
                                    input logic [4:0] pre);
    logic t;
    t = 1'b0;
    case (sel)
      2'h0: t = &pre[4:0];
      2'h1: t = &pre[3:0];
      2'h2: t = &pre[1:0];
      default: t = pre[0];
    endcase
    return t;
  endfunction : dmt_tick

  function automatic logic [7:0] dmt_inc8(input logic [7:0] v,
                                          input logic       clr);
    logic [7:0] r;
    r = clr ? 8'h00 : v + 8'h01;
    return r;
  endfunction : dmt_inc8

  dmt_pkg::dmt_state_type q_r;
  dmt_pkg::dmt_state_type s_nxt;

  logic        mode8;
  logic        tick_lo;
  logic        tick_hi;
  logic        ext_edge;
  logic        m_hi;
  logic        m_lo;
  logic        ov_hi;
  logic        ov_lo;
  logic        clr_hi;
  logic        clr_lo;
  logic        w_ctrl;
  logic        w_stat;
  logic        w_cnth;
  logic        w_cntl;
  logic        w_cmph;
  logic        w_cmpl;
  logic        w_cfg;
  logic        r_stat;
  logic        r_cnth;
  logic        r_cntl;
  logic [7:0]  flag_ev;
  logic [7:0]  flag_clr;
  logic [15:0] cnt_inc;

  // =====================================================================
  // combinational next state
  // =====================================================================
  always_comb begin
    s_nxt    = q_r;
    w_ctrl   = 1'b0;
    w_stat   = 1'b0;
    w_cnth   = 1'b0;
    w_cntl   = 1'b0;
    w_cmph   = 1'b0;
    w_cmpl   = 1'b0;
    w_cfg    = 1'b0;
    r_stat   = 1'b0;
    r_cnth   = 1'b0;
    r_cntl   = 1'b0;
    m_hi     = 1'b0;
    m_lo     = 1'b0;
    ov_hi    = 1'b0;
    ov_lo    = 1'b0;
    clr_hi   = 1'b0;
    clr_lo   = 1'b0;
    flag_ev  = 8'h00;
    flag_clr = 8'h00;
    cnt_inc  = q_r.cnt + 16'h0001;

    // address decode
    if (bus_in.addr == dmt_pkg::OFS_CTRL) begin
      w_ctrl = bus_in.wr;
    end else if (bus_in.addr == dmt_pkg::OFS_STAT) begin
      w_stat = bus_in.wr;
      r_stat = bus_in.rd;
    end else if (bus_in.addr == dmt_pkg::OFS_CNT_HI) begin
      w_cnth = bus_in.wr;
      r_cnth = bus_in.rd;
    end else if (bus_in.addr == dmt_pkg::OFS_CNT_LO) begin
      w_cntl = bus_in.wr;
      r_cntl = bus_in.rd;
    end else if (bus_in.addr == dmt_pkg::OFS_CMP_HI) begin
      w_cmph = bus_in.wr;
    end else if (bus_in.addr == dmt_pkg::OFS_CMP_LO) begin
      w_cmpl = bus_in.wr;
    end else if (bus_in.addr == dmt_pkg::OFS_CFG) begin
      w_cfg = bus_in.wr;
    end

    mode8 = q_r.ctrl[dmt_pkg::CTL_UPPER_CS_HI];

    // counter clocks
    s_nxt.pre      = q_r.pre + 5'h01;
    s_nxt.evt_prev = event_count_input_in;
    ext_edge = q_r.cfg[dmt_pkg::CFG_EDGE_RISE] ?
               (event_count_input_in & ~q_r.evt_prev) :
               (~event_count_input_in & q_r.evt_prev);
    tick_lo = ~power_halt_in &
              (q_r.ctrl[dmt_pkg::CTL_LOWER_CS_HI] ?
               dmt_tick(q_r.ctrl[1:0], q_r.pre) : ext_edge);
    tick_hi = ~power_halt_in & dmt_tick(q_r.ctrl[5:4], q_r.pre);

    // compare, clear, overflow
    if (!mode8) begin
      // whole-word match fires on the lower clock tick leaving it
      m_hi = tick_lo & (q_r.cnt == q_r.cmp) & ~w_cmpl;
      m_lo = tick_lo & (q_r.cnt[7:0] == q_r.cmp[7:0]) &
             ~w_cmpl;
      clr_hi = m_hi & q_r.stat[dmt_pkg::ST_UPPER_CCLR];
      ov_hi = tick_lo & ~clr_hi & (q_r.cnt == 16'hFFFF) &
              ~w_cntl;
      ov_lo = tick_lo & ~clr_hi & (q_r.cnt[7:0] == 8'hFF) &
              ~w_cntl;
      if (clr_hi) begin
        s_nxt.cnt = 16'h0000;
      end else if (tick_lo) begin
        s_nxt.cnt = cnt_inc;
      end
    end else begin
      m_hi = tick_hi & (q_r.cnt[15:8] == q_r.cmp[15:8]) &
             ~w_cmph;
      m_lo = tick_lo & (q_r.cnt[7:0] == q_r.cmp[7:0]) &
             ~w_cmpl;
      clr_hi = m_hi & q_r.stat[dmt_pkg::ST_UPPER_CCLR];
      clr_lo = m_lo & q_r.stat[dmt_pkg::ST_LOWER_CCLR];
      ov_hi = tick_hi & ~clr_hi & (q_r.cnt[15:8] == 8'hFF) &
              ~w_cnth;
      ov_lo = tick_lo & ~clr_lo & (q_r.cnt[7:0] == 8'hFF) &
              ~w_cntl;
      if (tick_hi) begin
        s_nxt.cnt[15:8] = dmt_inc8(q_r.cnt[15:8], clr_hi);
      end
      if (tick_lo) begin
        s_nxt.cnt[7:0] = dmt_inc8(q_r.cnt[7:0], clr_lo);
      end
    end

    // byte access, 16-bit writes and count reads pass through the holding byte
    if (!mode8) begin
      if (w_cnth || w_cmph) begin
        s_nxt.temp = bus_in.wdata;
      end
      if (r_cnth) begin
        s_nxt.temp = q_r.cnt[7:0];
      end
      if (w_cntl) begin
        s_nxt.cnt = {q_r.temp, bus_in.wdata};
      end
      if (w_cmpl) begin
        s_nxt.cmp = {q_r.temp, bus_in.wdata};
      end
    end else begin
      if (w_cnth) begin
        s_nxt.cnt[15:8] = bus_in.wdata;
      end
      if (w_cntl) begin
        s_nxt.cnt[7:0] = bus_in.wdata;
      end
      if (w_cmph) begin
        s_nxt.cmp[15:8] = bus_in.wdata;
      end
      if (w_cmpl) begin
        s_nxt.cmp[7:0] = bus_in.wdata;
      end
    end

    if (w_ctrl) begin
      s_nxt.ctrl = bus_in.wdata;
    end
    if (w_cfg) begin
      s_nxt.cfg = bus_in.wdata[2:0];
    end

    // flags: clear needs a prior read of one, a new event wins
    flag_ev[dmt_pkg::ST_UPPER_OVF] = ov_hi;
    flag_ev[dmt_pkg::ST_UPPER_CMF] = m_hi;
    flag_ev[dmt_pkg::ST_LOWER_OVF] = ov_lo;
    flag_ev[dmt_pkg::ST_LOWER_CMF] = m_lo;
    if (w_stat) begin
      flag_clr = q_r.armed & ~bus_in.wdata & dmt_pkg::ST_FLAG_MASK;
      s_nxt.stat = (bus_in.wdata & ~dmt_pkg::ST_FLAG_MASK) |
                   (q_r.stat & dmt_pkg::ST_FLAG_MASK);
    end
    s_nxt.stat = (s_nxt.stat & ~flag_clr) | flag_ev;
    if (r_stat) begin
      s_nxt.armed = q_r.stat & dmt_pkg::ST_FLAG_MASK;
    end else begin
      s_nxt.armed = q_r.armed & s_nxt.stat;
    end

    // compare pins
    if (w_ctrl) begin
      s_nxt.pin_hi = bus_in.wdata[dmt_pkg::CTL_UPPER_LEVEL];
      s_nxt.pin_lo = bus_in.wdata[dmt_pkg::CTL_LOWER_LEVEL];
    end else begin
      s_nxt.pin_hi = q_r.pin_hi ^ m_hi;
      s_nxt.pin_lo = q_r.pin_lo ^ m_lo;
    end

    // interrupt request levels
    s_nxt.irq_hi = s_nxt.cfg[dmt_pkg::CFG_UPPER_IEN] &
                   (s_nxt.stat[dmt_pkg::ST_UPPER_CMF] |
                    (s_nxt.stat[dmt_pkg::ST_UPPER_OVF] &
                     s_nxt.stat[dmt_pkg::ST_UPPER_OVIE]));
    s_nxt.irq_lo = s_nxt.cfg[dmt_pkg::CFG_LOWER_IEN] &
                   (s_nxt.stat[dmt_pkg::ST_LOWER_CMF] |
                    (s_nxt.stat[dmt_pkg::ST_LOWER_OVF] &
                     s_nxt.stat[dmt_pkg::ST_LOWER_OVIE]));

    // read data, valid only the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (bus_in.rd) begin
      if (bus_in.addr == dmt_pkg::OFS_CTRL) begin
        s_nxt.rdata = q_r.ctrl;
      end else if (r_stat) begin
        s_nxt.rdata = q_r.stat;
      end else if (r_cnth) begin
        s_nxt.rdata = q_r.cnt[15:8];
      end else if (r_cntl) begin
        s_nxt.rdata = mode8 ? q_r.cnt[7:0] : q_r.temp;
      end else if (bus_in.addr == dmt_pkg::OFS_CMP_HI) begin
        s_nxt.rdata = q_r.cmp[15:8];
      end else if (bus_in.addr == dmt_pkg::OFS_CMP_LO) begin
        s_nxt.rdata = q_r.cmp[7:0];
      end else if (bus_in.addr == dmt_pkg::OFS_CFG) begin
        s_nxt.rdata = {5'h00, q_r.cfg};
      end
    end
  end

  // =====================================================================
  // state register
  // =====================================================================
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q_r <= '{ctrl: dmt_pkg::RST_CTRL, stat: dmt_pkg::RST_STAT,
               cfg: dmt_pkg::RST_CFG, cnt: dmt_pkg::RST_COUNT,
               cmp: dmt_pkg::RST_COMPARE, temp: 8'h00, armed: 8'h00,
               pre: 5'h00, evt_prev: 1'b0, pin_hi: 1'b0, pin_lo: 1'b0,
               irq_hi: 1'b0, irq_lo: 1'b0, rdata: 8'h00};
    end else begin
      q_r <= s_nxt;
    end
  end

  assign rdata_out         = q_r.rdata;
  assign upper_compare_out = q_r.pin_hi;
  assign lower_compare_out = q_r.pin_lo;
  assign upper_irq_out     = q_r.irq_hi;
  assign lower_irq_out     = q_r.irq_lo;

  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  a_ctrl_pin_win: assert property (w_ctrl |=>
    upper_compare_out == $past(bus_in.wdata[7]))
    else $error("pin did not take written level");

  a_pin_toggle: assert property (m_hi && !w_ctrl |=>
    upper_compare_out != $past(upper_compare_out))
    else $error("upper pin did not toggle on match");

  a_cmp_flag_set: assert property (m_hi |=>
    q_r.stat[dmt_pkg::ST_UPPER_CMF])
    else $error("upper compare flag not set");

  a_clear_word: assert property (!mode8 && clr_hi && !w_cntl |=>
    q_r.cnt == 16'h0000)
    else $error("counter not cleared on match");

  a_ovf_word: assert property (!mode8 && tick_lo && !w_cntl &&
    q_r.cnt == 16'hFFFF && !clr_hi |=>
    q_r.stat[dmt_pkg::ST_UPPER_OVF] && q_r.cnt == 16'h0000)
    else $error("16-bit wrap not flagged");

  a_cmp_suppress: assert property (w_cmpl && !mode8 |->
    !m_hi && !m_lo)
    else $error("match not suppressed by compare write");

  a_ovf_drop: assert property (w_cntl |-> !ov_lo)
    else $error("overflow not dropped by count write");

  a_halt_hold: assert property (power_halt_in && !bus_in.wr |=>
    q_r.cnt == $past(q_r.cnt))
    else $error("counter moved while halted");

  a_no_tick: assert property (!tick_lo |-> !m_lo)
    else $error("lower match without its clock");

  a_lo_flag8: assert property (mode8 && m_lo |=>
    q_r.stat[dmt_pkg::ST_LOWER_CMF] ##1 1)
    else $error("lower compare flag not set");

  a_no_sw_set: assert property (w_stat && !ov_hi &&
    !q_r.stat[dmt_pkg::ST_UPPER_OVF] |=>
    !q_r.stat[dmt_pkg::ST_UPPER_OVF])
    else $error("software set a flag");

  a_irq_upper: assert property (upper_irq_out ==
    (q_r.cfg[dmt_pkg::CFG_UPPER_IEN] &&
     (q_r.stat[dmt_pkg::ST_UPPER_CMF] ||
      (q_r.stat[dmt_pkg::ST_UPPER_OVF] &&
       q_r.stat[dmt_pkg::ST_UPPER_OVIE]))))
    else $error("upper interrupt level wrong");

  a_irq_match: assert property (m_hi && !w_cfg &&
    q_r.cfg[dmt_pkg::CFG_UPPER_IEN] |=> upper_irq_out)
    else $error("upper match raised no interrupt");

  c_match_clear: cover property (m_hi && clr_hi);
  c_wrap_word: cover property (ov_hi && !mode8);
  c_mode8_both: cover property (mode8 && m_hi && m_lo);
  c_flag_clear: cover property (w_stat && (|flag_clr));

endmodule : dmt_timer

// file: sim/dmt_host.sv
module dmt_host (
  input  wire logic            clk_in,
  output dmt_pkg::dmt_bus_type bus_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // expected read data, oldest first
  logic [7:0] exp_q [$];
  int         seed = 85557;

  initial bus_out = '0;

  // ==========================
  // bus cycles
  // ==========================
  // strobes are released only by idle or replaced by the next cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
  endtask : rd

  // idle bus carries random address and data with both strobes low
  task automatic idle(input int n);
    bus_out <= '{addr: 3'($random(seed)), wdata: 8'($random(seed)),
                 wr: 1'b0, rd: 1'b0};
    repeat (n) @(posedge clk_in);
  endtask : idle

  // ==========================
  // 16-bit pairs, upper byte first
  // ==========================
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 3'h1, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [2:0] a, input logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 3'h1, v[7:0]);
  endtask : rd16
endmodule : dmt_host

// file: sim/dmt_timer_bench.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

module dmt_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                 clk_in   = 1'b0;
  logic                 rst_b_in = 1'b0;
  logic                 evt      = 1'b0;
  logic                 halt     = 1'b0;
  logic                 rd_d     = 1'b0;
  logic [7:0]           ex;
  logic [15:0]          v;
  logic [7:0]           rdata;
  logic                 up_pin, lo_pin, up_irq, lo_irq;
  dmt_pkg::dmt_bus_type bus;
  int                   fail_count  = 0;
  int                   comparisons = 0;
  int                   seed        = 85557;
  int                   div [4]     = '{32, 16, 4, 2};

  always #4 clk_in = ~clk_in;

  dmt_host host (.clk_in(clk_in), .bus_out(bus));

  dmt_timer dut (
    .clk_in              (clk_in),
    .rst_b_in            (rst_b_in),
    .bus_in              (bus),
    .event_count_input_in(evt),
    .power_halt_in       (halt),
    .rdata_out           (rdata),
    .upper_compare_out   (up_pin),
    .lower_compare_out   (lo_pin),
    .upper_irq_out       (up_irq),
    .lower_irq_out       (lo_irq)
  );

  // ==========================
  // read data monitor
  // ==========================
  always @(posedge clk_in) begin
    if (rd_d) begin
      ex = host.exp_q.pop_front();
      `CHK(rdata, ex)
    end
    rd_d <= bus.rd;
  end

  // ==========================
  // helpers
  // ==========================
  task automatic pulse(input int n);
    host.idle(0);
    repeat (n) begin
      evt <= 1'b1;
      repeat (2) @(posedge clk_in);
      evt <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask : pulse

  // order: upper pin, lower pin, upper irq, lower irq
  task automatic pins(input logic [3:0] e, input logic [3:0] m);
    host.idle(1);
    `CHK({up_pin, lo_pin, up_irq, lo_irq} & m, e)
  endtask : pins

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (6000) @(posedge clk_in);
    fail_count++;
    wrap_up();
  end

  // ==========================
  // tests
  // ==========================
  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    host.rd(dmt_pkg::OFS_CTRL, 8'h00);
    host.rd(dmt_pkg::OFS_STAT, 8'h00);
    host.rd16(dmt_pkg::OFS_CNT_HI, 16'h0000);
    host.rd16(dmt_pkg::OFS_CMP_HI, 16'hFFFF);
    host.rd(dmt_pkg::OFS_CFG, 8'h00);
    host.wr(3'h7, 8'hFF);
    host.rd(3'h7, 8'h00);
    pins(4'h0, 4'hF);
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      host.wr16(dmt_pkg::OFS_CMP_HI, v);
      host.rd16(dmt_pkg::OFS_CMP_HI, v);
    end
    done("reset_and_access");
    host.wr16(dmt_pkg::OFS_CMP_HI, 16'h0003);
    halt <= 1'b1;
    pulse(2);
    halt <= 1'b0;
    pulse(2);
    host.rd16(dmt_pkg::OFS_CNT_HI, 16'h0002);
    host.rd16(dmt_pkg::OFS_CMP_HI, 16'h0003);
    done("event_and_halt");
    host.wr(dmt_pkg::OFS_CFG, 8'h07);
    host.wr(dmt_pkg::OFS_STAT, 8'h10);
    host.wr16(dmt_pkg::OFS_CNT_HI, 16'h0000);
    pulse(3);
    host.rd(dmt_pkg::OFS_STAT, 8'h10);
    // lower pin left unchecked in 16-bit mode
    pins(4'h0, 4'hB);
    pulse(1);
    host.rd(dmt_pkg::OFS_STAT, 8'h54);
    host.rd16(dmt_pkg::OFS_CNT_HI, 16'h0000);
    pins(4'hB, 4'hB);
    host.wr(dmt_pkg::OFS_STAT, 8'h10);
    host.wr(dmt_pkg::OFS_STAT, 8'hDC);
    host.rd(dmt_pkg::OFS_STAT, 8'h10);
    pins(4'h8, 4'hB);
    done("match16");
    host.wr(dmt_pkg::OFS_STAT, 8'h30);
    host.wr16(dmt_pkg::OFS_CNT_HI, 16'hFFFE);
    pulse(2);
    host.rd(dmt_pkg::OFS_STAT, 8'hB8);
    pins(4'hA, 4'hB);
    host.wr(dmt_pkg::OFS_STAT, 8'h30);
    host.wr16(dmt_pkg::OFS_CNT_HI, 16'hFFFF);
    host.wr(dmt_pkg::OFS_CNT_HI, 8'hFF);
    evt <= 1'b1;
    host.wr(dmt_pkg::OFS_CNT_LO, 8'h12);
    host.idle(2);
    evt <= 1'b0;
    host.rd(dmt_pkg::OFS_STAT, 8'h30);
    host.rd16(dmt_pkg::OFS_CNT_HI, 16'hFF12);
    done("overflow16");
    host.wr16(dmt_pkg::OFS_CNT_HI, 16'h0003);
    host.wr(dmt_pkg::OFS_CTRL, 8'h80);
    evt <= 1'b1;
    host.wr(dmt_pkg::OFS_CTRL, 8'h80);
    host.idle(2);
    evt <= 1'b0;
    pins(4'h8, 4'h8);
    host.rd(dmt_pkg::OFS_STAT, 8'h74);
    host.wr(dmt_pkg::OFS_STAT, 8'h30);
    host.wr16(dmt_pkg::OFS_CNT_HI, 16'h0003);
    host.wr(dmt_pkg::OFS_CMP_HI, 8'h00);
    evt <= 1'b1;
    host.wr(dmt_pkg::OFS_CMP_LO, 8'h03);
    host.idle(2);
    evt <= 1'b0;
    host.rd(dmt_pkg::OFS_STAT, 8'h30);
    host.rd16(dmt_pkg::OFS_CNT_HI, 16'h0004);
    done("conflicts");
    host.wr(dmt_pkg::OFS_CTRL, 8'h48);
    host.wr(dmt_pkg::OFS_CNT_HI, 8'h00);
    host.wr(dmt_pkg::OFS_CMP_HI, 8'hFF);
    host.wr(dmt_pkg::OFS_CNT_LO, 8'hFF);
    host.wr(dmt_pkg::OFS_CMP_LO, 8'h01);
    host.wr(dmt_pkg::OFS_STAT, 8'h03);
    pins(4'h4, 4'hF);
    pulse(3);
    host.rd(dmt_pkg::OFS_STAT, 8'h0F);
    host.rd(dmt_pkg::OFS_CNT_LO, 8'h00);
    pins(4'h1, 4'hF);
    done("halves8");
    for (int i = 0; i < 4; i++) begin
      // both halves on internal clocks, random start below any wrap
      v = (16'($random(seed)) & 16'h3F3F) | 16'h0202;
      host.wr(dmt_pkg::OFS_CTRL, 8'h44 | (8'(i) << 4) | 8'(i));
      host.wr(dmt_pkg::OFS_CNT_HI, v[15:8]);
      host.wr(dmt_pkg::OFS_CNT_LO, v[7:0]);
      host.idle(319);
      host.rd(dmt_pkg::OFS_CNT_HI, v[15:8] + 8'(320 / div[i]));
      host.rd(dmt_pkg::OFS_CNT_LO, v[7:0] + 8'(320 / div[i]));
    end
    host.idle(2);
    done("prescaler");
    wrap_up();
  end
endmodule : dmt_timer_bench
